// ### design/fips_pkg.sv
// Notes on behaviour
// - The command interrupt is requested while the command complete flag and its enable are both set.
// - The error interrupt is requested from the double and single fault flags, each gated by its own enable.
// - Entering wait mode changes nothing in the controller's state or function.
// - The command complete interrupt is able to wake the processor from wait mode.
// - A stop request made while a command runs is granted only after that command completes.
// - During reset the security setting register is loaded from the security byte of the configuration field.
// - A newly programmed security byte never takes effect: the next reset re-seeds the stored byte to 8'hFE before the load.
// - Both factory-test reserved registers read as zero and ignore every write.
package fips_pkg;

   // ------------------------------------------------------------------
   // Register offsets
   // ------------------------------------------------------------------
   localparam logic [3:0] ADDR_CONFIG = 4'h0;
   localparam logic [3:0] ADDR_ERR_CONFIG = 4'h1;
   localparam logic [3:0] ADDR_STATUS = 4'h2;
   localparam logic [3:0] ADDR_ERR_STATUS = 4'h3;
   localparam logic [3:0] ADDR_SECURITY = 4'h4;
   localparam logic [3:0] ADDR_COMMAND = 4'h5;
   localparam logic [3:0] ADDR_RSV_ONE = 4'h6;
   localparam logic [3:0] ADDR_RSV_TWO = 4'h7;
   localparam logic [3:0] ADDR_IRQ_STATUS = 4'h8;
   localparam logic [3:0] ADDR_IRQ_ENABLE = 4'h9;
   localparam logic [3:0] ADDR_IRQ_CLEAR = 4'hA;
   localparam logic [3:0] ADDR_NV_SEC_BYTE = 4'hB;

   // ------------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------------
   localparam int BIT_COMMAND_COMPLETE_IRQ_ENABLE = 7;
   localparam int BIT_CCF = 7;
   localparam int BIT_DFIE = 1;
   localparam int BIT_SFIE = 0;
   localparam int BIT_DFF = 1;
   localparam int BIT_SFF = 0;
   localparam int BIT_EV_DONE = 0;
   localparam int BIT_EV_DFAULT = 1;
   localparam int BIT_EV_SFAULT = 2;
   localparam int BIT_EV_STOP = 3;

   // ------------------------------------------------------------------
   // Reset values, timing and addresses
   // ------------------------------------------------------------------
   localparam logic [17:0] SEC_BYTE_GLOBAL_ADDR = 18'h3FF0F;
   localparam logic [7:0] NV_SEC_BYTE_RESET = 8'hFE;
   localparam logic [7:0] RESET_ZERO = 8'h00;
   localparam logic [3:0] EVENT_ZERO = 4'h0;
   localparam int CLOCK_MHZ = 25;
   localparam int PROGRAM_TIME_US = 20;
   localparam int PROGRAM_CYCLES = PROGRAM_TIME_US * CLOCK_MHZ;
   localparam logic [9:0] PROGRAM_CYCLES_W = 10'(PROGRAM_CYCLES);

   typedef enum logic [1:0] {
      FIPS_IDLE,
      FIPS_LOAD_SEC,
      FIPS_BUSY
   } fips_state_type;

endpackage : fips_pkg

// ### design/fips_sync.sv
`timescale 1ns/1ps
module fips_sync (
   input wire logic clock_in,
   input wire logic rst_n_in,
   input wire logic async_in,
   output logic level_out
);
   typedef struct packed {
      logic [2:0] stage;
      logic level;
   } fips_sync_state_type;

   fips_sync_state_type state_reg;
   fips_sync_state_type state_next;

   // ----------------------------------------------------------------
   // Three stage capture, change taken when stages two and three agree
   // ----------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      state_next.stage = {state_reg.stage[1:0], async_in};
      if (state_reg.stage[1] == state_reg.stage[2]) begin
         state_next.level = state_reg.stage[2];
      end
   end

   // Register the state
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign level_out = state_reg.level;
endmodule : fips_sync

// ### design/fips_irq.sv
`timescale 1ns/1ps
module fips_irq (
   input wire logic clock_in,
   input wire logic rst_n_in,
   input wire logic [3:0] event_in,
   input wire logic [3:0] enable_in,
   input wire logic [3:0] clear_in,
   input wire logic clear_stb_in,
   output logic [3:0] status_out,
   output logic irq_out
);
   import fips_pkg::*;

   typedef struct packed {
      logic [3:0] status;
      logic irq;
   } fips_irq_state_type;

   fips_irq_state_type state_reg;
   fips_irq_state_type state_next;

   // ----------------------------------------------------------------
   // Sticky status, a new event wins over a clear in the same cycle
   // ----------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      if (clear_stb_in) begin
         state_next.status = state_reg.status & ~clear_in;
      end
      state_next.status = state_next.status | event_in;
      state_next.irq = |(state_next.status & enable_in);
   end

   // Register the state
   always_ff @(posedge clock_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign status_out = state_reg.status;
   assign irq_out = state_reg.irq;
endmodule : fips_irq

// ### design/fips_top.sv
`timescale 1ns/1ps
module fips_top (
   input wire logic clock_in,
   input wire logic reset_n_in,
   input wire logic [3:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic write_in,
   input wire logic read_in,
   output logic [7:0] rdata_out,
   input wire logic wait_mode_in,
   input wire logic stop_request_in,
   input wire logic double_fault_in,
   input wire logic single_fault_in,
   output logic stop_ack_out,
   output logic cmd_irq_out,
   output logic err_irq_out,
   output logic wake_out,
   output logic [7:0] security_out,
   output logic summary_irq_out
);
   import fips_pkg::*;

   typedef struct packed {
      fips_state_type state;
      logic [9:0] count;
      logic command_complete_flag;
      logic command_complete_irq_enable;
      logic double_fault_detect_flag;
      logic single_fault_detect_flag;
      logic double_fault_irq_enable;
      logic single_fault_irq_enable;
      logic [7:0] security_setting_register;
      logic [7:0] nv_sec_byte;
      logic nv_sec_programmed;
      logic [3:0] irq_enable;
      logic [7:0] rdata;
      logic stop_ack;
      logic cmd_irq;
      logic err_irq;
      logic wake;
      logic [3:0] events;
   } fips_top_state_type;

   fips_top_state_type state_reg;
   fips_top_state_type state_next;
   logic [1:0] rst_sync_reg;
   logic rst_n;
   logic stop_req_sync;
   logic dfault_sync;
   logic sfault_sync;
   logic [3:0] irq_status;
   logic irq_level;

   // ----------------------------------------------------------------
   // Reset release through two flip-flops
   // ----------------------------------------------------------------
   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         rst_sync_reg <= 2'h0;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_reg[1];

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   fips_sync u_sync_stop (
      .clock_in(clock_in),
      .rst_n_in(rst_n),
      .async_in(stop_request_in),
      .level_out(stop_req_sync)
   );
   fips_sync u_sync_dfault (
      .clock_in(clock_in),
      .rst_n_in(rst_n),
      .async_in(double_fault_in),
      .level_out(dfault_sync)
   );
   fips_sync u_sync_sfault (
      .clock_in(clock_in),
      .rst_n_in(rst_n),
      .async_in(single_fault_in),
      .level_out(sfault_sync)
   );

   // ----------------------------------------------------------------
   // Interrupt status, enable and clear
   // ----------------------------------------------------------------
   fips_irq u_irq (
      .clock_in(clock_in),
      .rst_n_in(rst_n),
      .event_in(state_reg.events),
      .enable_in(state_reg.irq_enable),
      .clear_in(wdata_in[3:0]),
      .clear_stb_in(write_in && addr_in == ADDR_IRQ_CLEAR),
      .status_out(irq_status),
      .irq_out(irq_level)
   );

   // Write hit helper
   function automatic logic wr_hit(input logic [3:0] a, input logic w, input logic [3:0] t);
      wr_hit = w && (a == t);
   endfunction : wr_hit

   // ----------------------------------------------------------------
   // Next state: sequencer, registers, requests
   // ----------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      state_next.events = EVENT_ZERO;
      // Sequencer; wait_mode_in deliberately plays no part here
      case (state_reg.state)
         FIPS_LOAD_SEC: begin
            // Security byte at the configuration field copied
            state_next.security_setting_register = state_reg.nv_sec_byte;
            state_next.state = FIPS_IDLE;
         end
         FIPS_IDLE: begin
            if (wr_hit(addr_in, write_in, ADDR_COMMAND) && state_reg.command_complete_flag) begin
               state_next.command_complete_flag = 1'b0;
               state_next.count = PROGRAM_CYCLES_W;
               state_next.state = FIPS_BUSY;
            end
         end
         FIPS_BUSY: begin
            if (state_reg.count == 10'h000) begin
               state_next.command_complete_flag = 1'b1;
               state_next.events[BIT_EV_DONE] = 1'b1;
               // Programming finished; live setting unchanged, and reset re-seeds the byte to 8'hFE
               if (state_reg.nv_sec_programmed) begin
                  state_next.nv_sec_programmed = 1'b0;
               end
               state_next.state = FIPS_IDLE;
            end else begin
               state_next.count = state_reg.count - 10'h001;
            end
         end
         default: begin
            state_next.state = FIPS_IDLE;
         end
      endcase
      // Fault flags set by events, set wins over clear
      if (wr_hit(addr_in, write_in, ADDR_ERR_STATUS)) begin
         if (wdata_in[BIT_DFF]) state_next.double_fault_detect_flag = 1'b0;
         if (wdata_in[BIT_SFF]) state_next.single_fault_detect_flag = 1'b0;
      end
      if (dfault_sync) begin
         state_next.double_fault_detect_flag = 1'b1;
         state_next.events[BIT_EV_DFAULT] = 1'b1;
      end
      if (sfault_sync) begin
         state_next.single_fault_detect_flag = 1'b1;
         state_next.events[BIT_EV_SFAULT] = 1'b1;
      end
      // Control writes
      if (wr_hit(addr_in, write_in, ADDR_CONFIG)) begin
         state_next.command_complete_irq_enable = wdata_in[BIT_COMMAND_COMPLETE_IRQ_ENABLE];
      end
      if (wr_hit(addr_in, write_in, ADDR_ERR_CONFIG)) begin
         state_next.double_fault_irq_enable = wdata_in[BIT_DFIE];
         state_next.single_fault_irq_enable = wdata_in[BIT_SFIE];
      end
      if (wr_hit(addr_in, write_in, ADDR_IRQ_ENABLE)) begin
         state_next.irq_enable = wdata_in[3:0];
      end
      // Program the non-volatile security byte; live setting untouched
      if (wr_hit(addr_in, write_in, ADDR_NV_SEC_BYTE) && state_reg.state == FIPS_IDLE
          && state_reg.command_complete_flag) begin
         state_next.nv_sec_byte = wdata_in;
         state_next.nv_sec_programmed = 1'b1;
         state_next.command_complete_flag = 1'b0;
         state_next.count = PROGRAM_CYCLES_W;
         state_next.state = FIPS_BUSY;
      end
      // Stop granted only when no command is running
      state_next.stop_ack = stop_req_sync && state_next.command_complete_flag
         && state_next.state == FIPS_IDLE;
      if (stop_req_sync && !state_reg.stop_ack && state_next.stop_ack) begin
         state_next.events[BIT_EV_STOP] = 1'b1;
      end
      // Command interrupt request
      state_next.cmd_irq = state_next.command_complete_flag
         && state_next.command_complete_irq_enable;
      // Error interrupt request
      state_next.err_irq = (state_next.double_fault_detect_flag
         && state_next.double_fault_irq_enable)
         || (state_next.single_fault_detect_flag && state_next.single_fault_irq_enable);
      // Wake from wait through the command interrupt
      state_next.wake = wait_mode_in && state_next.cmd_irq;
      // Read data, one cycle after the strobe
      state_next.rdata = RESET_ZERO;
      if (read_in) begin
         case (addr_in)
            ADDR_CONFIG: state_next.rdata[BIT_COMMAND_COMPLETE_IRQ_ENABLE] = state_reg.command_complete_irq_enable;
            ADDR_ERR_CONFIG: state_next.rdata = {6'h00, state_reg.double_fault_irq_enable,
               state_reg.single_fault_irq_enable};
            ADDR_STATUS: state_next.rdata[BIT_CCF] = state_reg.command_complete_flag;
            ADDR_ERR_STATUS: state_next.rdata = {6'h00, state_reg.double_fault_detect_flag,
               state_reg.single_fault_detect_flag};
            ADDR_SECURITY: state_next.rdata = state_reg.security_setting_register;
            ADDR_RSV_ONE: state_next.rdata = RESET_ZERO;
            ADDR_RSV_TWO: state_next.rdata = RESET_ZERO;
            ADDR_IRQ_STATUS: state_next.rdata = {4'h0, irq_status};
            ADDR_IRQ_ENABLE: state_next.rdata = {4'h0, state_reg.irq_enable};
            ADDR_NV_SEC_BYTE: state_next.rdata = state_reg.nv_sec_byte;
            default: state_next.rdata = RESET_ZERO;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // State register; the block reset also re-seeds the stored byte
   // ----------------------------------------------------------------
   always_ff @(posedge clock_in or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= '0;
         state_reg.state <= FIPS_LOAD_SEC;
         state_reg.command_complete_flag <= 1'b1;
         state_reg.nv_sec_byte <= NV_SEC_BYTE_RESET;
      end else begin
         state_reg <= state_next;
      end
   end

   assign rdata_out = state_reg.rdata;
   assign stop_ack_out = state_reg.stop_ack;
   assign cmd_irq_out = state_reg.cmd_irq;
   assign err_irq_out = state_reg.err_irq;
   assign wake_out = state_reg.wake;
   assign security_out = state_reg.security_setting_register;
   assign summary_irq_out = irq_level;
endmodule : fips_top

// ### bench/fips_top_sva.sv
`timescale 1ns/1ps
module fips_top_sva
   import fips_pkg::*;
(
   input wire logic clock_in,
   input wire logic reset_n_in,
   input wire logic [3:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic write_in,
   input wire logic read_in,
   input wire logic [7:0] rdata_out,
   input wire logic wait_mode_in,
   input wire logic stop_request_in,
   input wire logic stop_ack_out,
   input wire logic cmd_irq_out,
   input wire logic err_irq_out,
   input wire logic wake_out,
   input wire logic [7:0] security_out,
   input wire logic summary_irq_out
);
   logic [2:0] settle_reg;

   // Counts cycles after reset until the security load has surely landed
   always_ff @(posedge clock_in or negedge reset_n_in) begin
      if (!reset_n_in) begin
         settle_reg <= 3'h0;
      end else if (settle_reg != 3'h7) begin
         settle_reg <= settle_reg + 3'h1;
      end
   end

   // ------------------------------------------------------------------
   // Properties
   // ------------------------------------------------------------------
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!reset_n_in);

   sequence s_launch;
      write_in && addr_in == ADDR_COMMAND;
   endsequence
   sequence s_rsv_read;
      read_in && (addr_in == ADDR_RSV_ONE || addr_in == ADDR_RSV_TWO);
   endsequence

   property p_cmd_clear;
      s_launch |-> ##[1:2] (!cmd_irq_out)[*8];
   endproperty
   property p_stop_hold;
      s_launch |-> ##[1:3] (!stop_ack_out)[*8];
   endproperty
   property p_stop_idle;
      (!stop_request_in)[*6] |-> !stop_ack_out;
   endproperty
   property p_rsv_zero;
      s_rsv_read |=> rdata_out == RESET_ZERO;
   endproperty
   property p_sec_read;
      read_in && addr_in == ADDR_SECURITY |=> rdata_out == $past(security_out);
   endproperty
   property p_sec_stable;
      settle_reg == 3'h7 |-> $stable(security_out);
   endproperty
   property p_err_off;
      write_in && addr_in == ADDR_ERR_CONFIG && wdata_in[1:0] == 2'h0 |-> ##2 !err_irq_out;
   endproperty
   property p_cmd_off;
      write_in && addr_in == ADDR_CONFIG && !wdata_in[BIT_COMMAND_COMPLETE_IRQ_ENABLE] |-> ##2 !cmd_irq_out && !wake_out;
   endproperty
   property p_sum_off;
      write_in && addr_in == ADDR_IRQ_ENABLE && wdata_in[3:0] == 4'h0 |-> ##2 !summary_irq_out;
   endproperty
   property p_wake_off;
      (!wait_mode_in)[*2] |-> !wake_out;
   endproperty

   a_cmd_clear: assert property (p_cmd_clear) else $error("cmd irq stayed up");
   a_stop_hold: assert property (p_stop_hold) else $error("stop ack while busy");
   a_stop_idle: assert property (p_stop_idle) else $error("stop ack unasked");
   a_rsv_zero: assert property (p_rsv_zero) else $error("reserved read not zero");
   a_sec_read: assert property (p_sec_read) else $error("security read wrong");
   a_sec_stable: assert property (p_sec_stable) else $error("security changed");
   a_err_off: assert property (p_err_off) else $error("err irq not masked");
   a_cmd_off: assert property (p_cmd_off) else $error("cmd irq not masked");
   a_sum_off: assert property (p_sum_off) else $error("summary not masked");
   a_wake_off: assert property (p_wake_off) else $error("wake outside wait");
endmodule : fips_top_sva

// ### bench/test_fips_top.sv
`timescale 1ns/1ps
module test_fips_top;
   import fips_pkg::*;
   logic clock_in, reset_n_in, write_in, read_in, wait_mode_in, stop_request_in;
   logic double_fault_in, single_fault_in;
   logic stop_ack_out, cmd_irq_out, err_irq_out, wake_out, summary_irq_out;
   logic [3:0] addr_in;
   logic [7:0] wdata_in, rdata_out, security_out, value;
   int failures = 0;
   int checks_done = 0;
   int n;

   // Free running clock
   always #20 clock_in = ~clock_in;

   fips_top fips_top_i (.clock_in(clock_in), .reset_n_in(reset_n_in), .addr_in(addr_in),
      .wdata_in(wdata_in), .write_in(write_in), .read_in(read_in), .rdata_out(rdata_out),
      .wait_mode_in(wait_mode_in), .stop_request_in(stop_request_in),
      .double_fault_in(double_fault_in), .single_fault_in(single_fault_in),
      .stop_ack_out(stop_ack_out), .cmd_irq_out(cmd_irq_out), .err_irq_out(err_irq_out),
      .wake_out(wake_out), .security_out(security_out), .summary_irq_out(summary_irq_out));

   // ------------------------------------------------------------------
   // Tasks
   // ------------------------------------------------------------------
   task check(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task cyc(input int c);
      repeat (c) @(posedge clock_in);
      #1;
   endtask : cyc

   task wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clock_in);
      addr_in <= a;
      wdata_in <= d;
      write_in <= 1'b1;
      @(posedge clock_in);
      write_in <= 1'b0;
   endtask : wr

   task rd(input logic [3:0] a, output logic [7:0] v);
      @(posedge clock_in);
      addr_in <= a;
      read_in <= 1'b1;
      @(posedge clock_in);
      read_in <= 1'b0;
      #1 v = rdata_out;
   endtask : rd

   task fault(input logic dbl);
      @(posedge clock_in);
      double_fault_in <= dbl;
      single_fault_in <= !dbl;
      // Held three edges so the pin filter sees two agreeing stages
      repeat (3) @(posedge clock_in);
      double_fault_in <= 1'b0;
      single_fault_in <= 1'b0;
      cyc(8);
   endtask : fault

   task final_report;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : final_report

   // ------------------------------------------------------------------
   // Tests
   // ------------------------------------------------------------------
   initial begin
      clock_in = 1'b0;
      reset_n_in = 1'b0;
      {write_in, read_in, wait_mode_in, stop_request_in} = 4'h0;
      {double_fault_in, single_fault_in} = 2'h0;
      addr_in = 4'h0;
      wdata_in = 8'h00;
      repeat (10) @(posedge clock_in);
      reset_n_in <= 1'b1;
      cyc(4);
      check(security_out, NV_SEC_BYTE_RESET);
      rd(ADDR_SECURITY, value);
      check(value, NV_SEC_BYTE_RESET);
      rd(ADDR_STATUS, value);
      check(value & 8'h80, 8'h80);
      for (n = 0; n < 2; n++) begin
         wr(n ? ADDR_RSV_TWO : ADDR_RSV_ONE, 8'hFF);
         rd(n ? ADDR_RSV_TWO : ADDR_RSV_ONE, value);
         check(value, RESET_ZERO);
      end
      rd(4'hF, value);
      check(value, RESET_ZERO);
      $display("test reset and reserved done");
      // Command completion in wait mode wakes the processor
      wr(ADDR_CONFIG, 8'h80);
      cyc(2);
      check(cmd_irq_out, 1'b1);
      @(posedge clock_in) wait_mode_in <= 1'b1;
      wr(ADDR_COMMAND, 8'h01);
      cyc(3);
      check({cmd_irq_out, wake_out}, 8'h00);
      for (n = 0; cmd_irq_out !== 1'b1 && n < 700; n++) cyc(1);
      check(8'(n >= 494 && n <= 502), 8'h01);
      cyc(2);
      check(wake_out, 1'b1);
      @(posedge clock_in) wait_mode_in <= 1'b0;
      cyc(3);
      check(wake_out, 1'b0);
      wr(ADDR_IRQ_ENABLE, 8'h01);
      cyc(2);
      check(summary_irq_out, 1'b1);
      rd(ADDR_IRQ_STATUS, value);
      check(value & 8'h01, 8'h01);
      wr(ADDR_IRQ_CLEAR, 8'h01);
      cyc(2);
      check(summary_irq_out, 1'b0);
      wr(ADDR_IRQ_ENABLE, 8'h00);
      wr(ADDR_CONFIG, 8'h00);
      cyc(2);
      check(cmd_irq_out, 1'b0);
      $display("test command interrupt done");
      // Stop waits for the running command
      @(posedge clock_in) stop_request_in <= 1'b1;
      cyc(8);
      check(stop_ack_out, 1'b1);
      wr(ADDR_COMMAND, 8'h01);
      cyc(3);
      check(stop_ack_out, 1'b0);
      for (n = 0; stop_ack_out !== 1'b1 && n < 700; n++) cyc(1);
      check(8'(n >= 490 && n <= 503), 8'h01);
      @(posedge clock_in) stop_request_in <= 1'b0;
      $display("test stop done");
      // Error interrupt with separate enables
      wr(ADDR_ERR_CONFIG, 8'h02);
      fault(1'b0);
      check(err_irq_out, 1'b0);
      fault(1'b1);
      check(err_irq_out, 1'b1);
      wr(ADDR_ERR_CONFIG, 8'h00);
      cyc(2);
      check(err_irq_out, 1'b0);
      wr(ADDR_ERR_CONFIG, 8'h01);
      cyc(2);
      check(err_irq_out, 1'b1);
      rd(ADDR_ERR_STATUS, value);
      check(value & 8'h03, 8'h03);
      wr(ADDR_ERR_STATUS, 8'h03);
      cyc(2);
      check(err_irq_out, 1'b0);
      $display("test error interrupt done");
      // Programmed security byte is lost at the next reset
      wr(ADDR_NV_SEC_BYTE, 8'h5A);
      cyc(520);
      rd(ADDR_NV_SEC_BYTE, value);
      check(value, 8'h5A);
      check(security_out, NV_SEC_BYTE_RESET);
      rd(ADDR_SECURITY, value);
      check(value, NV_SEC_BYTE_RESET);
      @(posedge clock_in) reset_n_in <= 1'b0;
      @(posedge clock_in) reset_n_in <= 1'b1;
      cyc(4);
      check(security_out, NV_SEC_BYTE_RESET);
      $display("test security done");
      final_report();
   end

   // Watchdog against a hang
   initial begin
      #(5000 * 40);
      failures++;
      final_report();
   end
endmodule : test_fips_top

bind fips_top fips_top_sva fips_top_sva_i (.clock_in(clock_in), .reset_n_in(reset_n_in),
   .addr_in(addr_in), .wdata_in(wdata_in), .write_in(write_in), .read_in(read_in),
   .rdata_out(rdata_out), .wait_mode_in(wait_mode_in), .stop_request_in(stop_request_in),
   .stop_ack_out(stop_ack_out), .cmd_irq_out(cmd_irq_out), .err_irq_out(err_irq_out),
   .wake_out(wake_out), .security_out(security_out), .summary_irq_out(summary_irq_out));
